// ==== rtl/event_bank_pkg.sv ====
// Purpose: constants for the charger event flag and mask bank
// Assumes: byte-wide register port from the serial front end
// Notes: offsets are register addresses on the device's internal port
package event_bank_pkg;

  // =========================================================
  // register addresses
  localparam logic [7:0] charger_flags_addr = 8'h03;
  localparam logic [7:0] thermistor_flags_addr = 8'h05;
  localparam logic [7:0] timer_fault_flags_addr = 8'h06;
  localparam logic [7:0] charger_masks_addr = 8'h07;
  localparam logic [7:0] supply_temp_masks_addr = 8'h08;

  // =========================================================
  // reset values
  localparam logic [7:0] flags_reset = 8'h00;
  localparam logic [7:0] masks_reset = 8'h00;

  // =========================================================
  // timer and fault event bit positions
  localparam int watchdog_expiry_bit = 6;
  localparam int charge_timer_expiry_bit = 5;
  localparam int regulator_overcurrent_bit = 4;
  localparam int button_wake_first_bit = 2;
  localparam int button_wake_second_bit = 1;
  localparam int button_reset_warning_bit = 0;
  localparam int thermistor_missing_bit = 0;

  // =========================================================
  // charger event bit positions (shared by flags and masks)
  localparam int taper_entry_bit = 6;
  localparam int charge_done_bit = 5;
  localparam int input_limit_bit = 4;
  localparam int path_management_bit = 3;
  localparam int input_sag_bit = 2;
  localparam int die_heat_bit = 1;
  localparam int input_good_change_bit = 0;

  // =========================================================
  // supply and temperature mask bit positions
  localparam int input_overvoltage_bit = 7;
  localparam int cell_overcurrent_bit = 5;
  localparam int cell_undervoltage_bit = 4;
  localparam int cold_region_bit = 3;
  localparam int cool_region_bit = 2;
  localparam int warm_region_bit = 1;
  localparam int hot_region_bit = 0;

  // =========================================================
  // implemented bits of each flag register
  localparam logic [7:0] timer_fault_used = 8'h77;
  localparam logic [7:0] charger_used = 8'h7f;
  localparam logic [7:0] thermistor_used = 8'h01;

endpackage : event_bank_pkg

// ==== rtl/flag_byte.sv ====
// Purpose: one byte of sticky clear-on-read event flags
// Assumes: events are one-cycle or level, sampled every clock
// Notes: an event in the read cycle survives the clear
`timescale 1ns/100ps
module flag_byte (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // events and read strobe
  input wire logic [7:0] event_in,
  input wire logic [7:0] used,
  input wire logic read_clear,
  // flag state
  output logic [7:0] flags,
  output logic [7:0] newly_set
);

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] newly_set;
  } flag_state_t;

  flag_state_t state;
  flag_state_t next_state;

  // =========================================================
  // next state
  always_comb begin
    next_state = state;
    next_state.newly_set = event_in & used & ~state.flags;
    if (read_clear) begin
      next_state.flags = 8'h00;
    end
    next_state.flags = next_state.flags | (event_in & used);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flags = state.flags;
  assign newly_set = state.newly_set;

endmodule : flag_byte

// ==== rtl/charger_event_flag_mask_bank.sv ====
// Purpose: event flags, interrupt masks and interrupt request of charger
// Assumes: serial front end gives one-cycle read and write strobes
// Notes: read data is registered, valid the cycle after the read strobe
`timescale 1ns/100ps

// Summary of operation
// - timer fault flags at 0x6, clear on read
// - bit 6 sets on watchdog expiry
// - bit 5 sets on safety timer expiry
// - bit 4 sets on regulator overcurrent
// - bit 2 sets on first wake timer
// - bit 1 sets on second wake timer
// - bit 0 sets on reset warning timer
// - thermistor open flag bit 0, clear on read
// - charger mask at 0x7, read/write, resets zero
// - bit 6 masks taper entry interrupt
// - bit 5 masks charge termination interrupt
// - bit 4 masks input current limit interrupt
// - bit 3 masks power path management interrupt
// - bit 2 masks input voltage regulation interrupt
// - bit 1 masks thermal regulation interrupt
// - bit 0 masks input power good interrupt
// - supply temperature mask at 0x8, read/write
// - bit 7 masks input overvoltage interrupt
// - bit 5 masks cell overcurrent interrupt
// - bit 4 masks cell undervoltage interrupt
// - bits 3,2 mask cold and cool
// - bits 1,0 mask warm and hot
// - no power good interrupt at low-battery power up
// - charger flags at 0x3, clear on read
module charger_event_flag_mask_bank (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // timer and fault events
  input wire logic watchdog_expiry_event,
  input wire logic charge_timer_expiry_event,
  input wire logic regulator_overcurrent_event,
  input wire logic button_wake_first_event,
  input wire logic button_wake_second_event,
  input wire logic button_reset_warning_event,
  input wire logic thermistor_missing_event,
  // charger events
  input wire logic [6:0] charger_event,
  input wire logic powerup_low_battery,
  // supply and temperature events gated by the second mask
  input wire logic [7:0] supply_temp_event,
  // interrupt request and mask view
  output logic irq_pulse,
  output logic [7:0] supply_temp_gate
);

  typedef struct packed {
    logic [7:0] charger_event_masks;
    logic [7:0] supply_temp_event_masks;
    logic [7:0] reg_rdata;
    logic irq_pulse;
    logic [7:0] supply_temp_gate;
  } bank_state_t;

  bank_state_t state;
  bank_state_t next_state;

  logic [7:0] timer_events;
  logic [7:0] charger_events;
  logic [7:0] thermistor_events;
  logic [7:0] timer_fault_event_flags;
  logic [7:0] charger_event_flags;
  logic [7:0] thermistor_fault_flags;
  logic [7:0] timer_new;
  logic [7:0] charger_new;
  logic [7:0] thermistor_new;
  logic read_timer;
  logic read_charger;
  logic read_thermistor;

  // =========================================================
  // event collection
  always_comb begin
    timer_events = 8'h00;
    timer_events[event_bank_pkg::watchdog_expiry_bit] =
      watchdog_expiry_event;
    timer_events[event_bank_pkg::charge_timer_expiry_bit] =
      charge_timer_expiry_event;
    timer_events[event_bank_pkg::regulator_overcurrent_bit] =
      regulator_overcurrent_event;
    timer_events[event_bank_pkg::button_wake_first_bit] =
      button_wake_first_event;
    timer_events[event_bank_pkg::button_wake_second_bit] =
      button_wake_second_event;
    timer_events[event_bank_pkg::button_reset_warning_bit] =
      button_reset_warning_event;
    thermistor_events = 8'h00;
    thermistor_events[event_bank_pkg::thermistor_missing_bit] =
      thermistor_missing_event;
    charger_events = {1'b0, charger_event};
  end

  // =========================================================
  // clear-on-read strobes
  assign read_timer = reg_read &&
    reg_addr == event_bank_pkg::timer_fault_flags_addr;
  assign read_charger = reg_read &&
    reg_addr == event_bank_pkg::charger_flags_addr;
  assign read_thermistor = reg_read &&
    reg_addr == event_bank_pkg::thermistor_flags_addr;

  // =========================================================
  // flag registers
  flag_byte timer_flag_byte (
    .mclk(mclk),
    .rst(rst),
    .event_in(timer_events),
    .used(event_bank_pkg::timer_fault_used),
    .read_clear(read_timer),
    .flags(timer_fault_event_flags),
    .newly_set(timer_new)
  );

  flag_byte charger_flag_byte (
    .mclk(mclk),
    .rst(rst),
    .event_in(charger_events),
    .used(event_bank_pkg::charger_used),
    .read_clear(read_charger),
    .flags(charger_event_flags),
    .newly_set(charger_new)
  );

  flag_byte thermistor_flag_byte (
    .mclk(mclk),
    .rst(rst),
    .event_in(thermistor_events),
    .used(event_bank_pkg::thermistor_used),
    .read_clear(read_thermistor),
    .flags(thermistor_fault_flags),
    .newly_set(thermistor_new)
  );

  // =========================================================
  // next state
  always_comb begin
    logic [7:0] charger_open;
    charger_open = 8'h00;
    next_state = state;
    // mask writes
    if (reg_write) begin
      if (reg_addr == event_bank_pkg::charger_masks_addr) begin
        next_state.charger_event_masks = reg_wdata;
      end
      if (reg_addr == event_bank_pkg::supply_temp_masks_addr) begin
        next_state.supply_temp_event_masks = reg_wdata;
      end
    end
    // register read data
    if (reg_read) begin
      unique case (reg_addr)
        event_bank_pkg::charger_flags_addr: begin
          next_state.reg_rdata = charger_event_flags;
        end
        event_bank_pkg::thermistor_flags_addr: begin
          next_state.reg_rdata = thermistor_fault_flags;
        end
        event_bank_pkg::timer_fault_flags_addr: begin
          next_state.reg_rdata = timer_fault_event_flags;
        end
        event_bank_pkg::charger_masks_addr: begin
          next_state.reg_rdata = state.charger_event_masks;
        end
        event_bank_pkg::supply_temp_masks_addr: begin
          next_state.reg_rdata = state.supply_temp_event_masks;
        end
        default: begin
          next_state.reg_rdata = 8'h00;
        end
      endcase
    end
    // charger interrupt gating, mask bit 1 suppresses
    charger_open = charger_new & ~state.charger_event_masks;
    // per-bit masks
    if (powerup_low_battery) begin
      charger_open[event_bank_pkg::input_good_change_bit] = 1'b0;
    end
    // supply and temperature gates: high means event may interrupt
    next_state.supply_temp_gate =
      supply_temp_event & ~state.supply_temp_event_masks;
    // interrupt request from open charger, new timer and thermistor, and supply gate bits
    next_state.irq_pulse = (|charger_open) || (|timer_new) ||
      (|thermistor_new) || (|next_state.supply_temp_gate);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state.charger_event_masks <= event_bank_pkg::masks_reset;
      state.supply_temp_event_masks <= event_bank_pkg::masks_reset;
      state.reg_rdata <= event_bank_pkg::flags_reset;
      state.irq_pulse <= 1'b0;
      state.supply_temp_gate <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.reg_rdata;
  assign irq_pulse = state.irq_pulse;
  assign supply_temp_gate = state.supply_temp_gate;

endmodule : charger_event_flag_mask_bank

// ==== verif/bank_checker_assertions.sv ====
// Purpose: port checks for the event flag and mask bank
// Assumes: one clock, asynchronous active high reset
// Notes: mask copies are rebuilt from observed writes
`timescale 1ns/100ps
module bank_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // supply events and outputs
  input wire logic [7:0] supply_temp_event,
  input wire logic irq_pulse,
  input wire logic [7:0] supply_temp_gate
);
  logic [7:0] mc;
  logic [7:0] ms;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================
  // mask copies
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mc <= 8'h00;
      ms <= 8'h00;
    end else if (reg_write) begin
      if (reg_addr == 8'h07) mc <= reg_wdata;
      if (reg_addr == 8'h08) ms <= reg_wdata;
    end
  end
  // ==========================================
  // properties
  AST_MASK_RD7: assert property (
    reg_read && reg_addr == 8'h07 |=> reg_rdata == mc)
    else $error("charger mask read wrong");
  AST_MASK_RD8: assert property (
    reg_read && reg_addr == 8'h08 |=> reg_rdata == ms)
    else $error("supply mask read wrong");
  AST_UNMAPPED: assert property (
    reg_read && reg_addr > 8'h08 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_TIMER_RSV: assert property (
    reg_read && reg_addr == 8'h06 |=> !reg_rdata[7] && !reg_rdata[3])
    else $error("timer flag spare bits set");
  AST_THERM_RSV: assert property (
    reg_read && reg_addr == 8'h05 |=> reg_rdata[7:1] == 7'h00)
    else $error("thermistor spare bits set");
  AST_RD_HOLD: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data moved without read");
  AST_GATE: assert property (
    1 |=> supply_temp_gate == ($past(supply_temp_event) & ~$past(ms)))
    else $error("supply gate wrong");
  AST_GATE_IRQ: assert property (
    supply_temp_gate != 8'h00 |-> irq_pulse)
    else $error("gate without interrupt");
  COV_WRITE: cover property (reg_write && reg_addr == 8'h07);
  COV_IRQ: cover property (irq_pulse);
  COV_GATE: cover property (supply_temp_gate != 8'h00);
  COV_TIMER_READ: cover property (reg_read && reg_addr == 8'h06);
endmodule : bank_checker

bind charger_event_flag_mask_bank bank_checker u_chk (.mclk(mclk),
  .rst(rst), .reg_read(reg_read), .reg_write(reg_write),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .supply_temp_event(supply_temp_event), .irq_pulse(irq_pulse),
  .supply_temp_gate(supply_temp_gate));

// ==== verif/host_port_model.sv ====
// Purpose: host side of the register port
// Assumes: strobes launched on the falling edge
// Notes: released address and data lines show inverted junk
`timescale 1ns/100ps
module host_port_model (
  // clock
  input wire logic mclk,
  // register port
  output logic reg_read,
  output logic reg_write,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_read = 1'b0;
    reg_write = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(negedge mclk);
    reg_write = w;
    reg_read = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : acc
endmodule : host_port_model

// ==== verif/tb_charger_event_flag_mask_bank.sv ====
// Purpose: self-checking bench for the event flag and mask bank
// Assumes: masks and flags start at zero
// Notes: interrupt pulses are counted on every falling edge
`timescale 1ns/100ps
module tb_charger_event_flag_mask_bank;
  logic mclk, rst, pl, tm, rd, wr, irq;
  logic [5:0] tev;
  logic [6:0] cev;
  logic [7:0] sev, ad, wd, rdat, gate;
  int errors, checked, irqs, n;
  int pos [6] = '{6, 5, 4, 2, 1, 0};
  charger_event_flag_mask_bank uut (.mclk(mclk), .rst(rst),
    .reg_read(rd), .reg_write(wr), .reg_addr(ad), .reg_wdata(wd),
    .reg_rdata(rdat), .watchdog_expiry_event(tev[5]),
    .charge_timer_expiry_event(tev[4]),
    .regulator_overcurrent_event(tev[3]),
    .button_wake_first_event(tev[2]), .button_wake_second_event(tev[1]),
    .button_reset_warning_event(tev[0]), .thermistor_missing_event(tm),
    .charger_event(cev), .powerup_low_battery(pl),
    .supply_temp_event(sev), .irq_pulse(irq), .supply_temp_gate(gate));
  host_port_model host (.mclk(mclk), .reg_read(rd), .reg_write(wr),
    .reg_addr(ad), .reg_wdata(wd), .reg_rdata(rdat));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    if (irq === 1'b1) irqs++;
  end
  task automatic summarize;
    $display("compares %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.acc(1'b0, a, 8'h00);
    chk(rdat, exp);
  endtask : rchk
  // one-cycle event pulse, then count interrupt pulses
  task automatic kick(input logic [5:0] t, input logic m,
                      input logic [6:0] c, input logic [7:0] ni);
    n = irqs;
    @(negedge mclk);
    tev = t;
    tm = m;
    cev = c;
    @(negedge mclk);
    tev = '0;
    tm = 1'b0;
    cev = '0;
    repeat (4) @(negedge mclk);
    chk(8'(irqs - n), ni);
  endtask : kick
  initial begin
    #1_000_000;
    errors++;
    summarize();
  end
  initial begin
    {rst, pl, tm, tev, cev, sev} = {1'b1, 23'h0};
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    foreach (pos[i]) rchk(8'h03 + 8'(i), 8'h00);
    rchk(8'h20, 8'h00);
    host.acc(1'b1, 8'h07, 8'ha5);
    host.acc(1'b1, 8'h08, 8'h5a);
    host.acc(1'b1, 8'h06, 8'hff);
    rchk(8'h07, 8'ha5);
    rchk(8'h08, 8'h5a);
    rchk(8'h06, 8'h00);
    host.acc(1'b1, 8'h07, 8'h00);
    host.acc(1'b1, 8'h08, 8'h00);
    $display("register test done");
    foreach (pos[i]) begin
      kick(6'(1 << (5 - i)), 1'b0, 7'h00, 8'h01);
      rchk(8'h06, 8'(1 << pos[i]));
      rchk(8'h06, 8'h00);
    end
    kick(6'h00, 1'b1, 7'h00, 8'h01);
    rchk(8'h05, 8'h01);
    rchk(8'h05, 8'h00);
    $display("timer flag test done");
    for (int i = 0; i < 7; i++) begin
      host.acc(1'b1, 8'h07, 8'(1 << i));
      kick(6'h00, 1'b0, 7'(1 << i), 8'h00);
      rchk(8'h03, 8'(1 << i));
      host.acc(1'b1, 8'h07, 8'h00);
      kick(6'h00, 1'b0, 7'(1 << i), 8'h01);
      rchk(8'h03, 8'(1 << i));
    end
    pl = 1'b1;
    kick(6'h00, 1'b0, 7'h01, 8'h00);
    host.acc(1'b0, 8'h03, 8'h00);
    pl = 1'b0;
    $display("charger mask test done");
    host.acc(1'b1, 8'h08, 8'h0f);
    sev = 8'hbf;
    repeat (2) @(negedge mclk);
    chk(gate, 8'hb0);
    host.acc(1'b1, 8'h08, 8'hf0);
    repeat (2) @(negedge mclk);
    chk(gate, 8'h0f);
    sev = 8'h00;
    $display("supply mask test done");
    summarize();
  end
endmodule : tb_charger_event_flag_mask_bank
